/* File: hw/lcd_pixel_pkg.sv */
package lcd_pixel_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PINS_W = 18;

  // Register byte addresses.
  localparam logic [7:0] LCD_CONTROL_OFS   = 8'h00;
  localparam logic [7:0] LCD_STATUS_OFS    = 8'h04;
  localparam logic [7:0] DESC_ADDR0_OFS    = 8'h08;
  localparam logic [7:0] DESC_ADDR1_OFS    = 8'h0c;
  localparam logic [7:0] OVERLAY_CFG_OFS   = 8'h10;
  localparam logic [7:0] OVERLAY_CTRL_OFS  = 8'h14;

  // Control register fields.
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_DISABLE_BIT = 1;
  localparam int CTRL_BURST_LSB   = 2;
  localparam int CTRL_PANEL_LSB   = 4;
  localparam int CTRL_FORMAT_LSB  = 7;
  localparam int CTRL_DUAL_BIT    = 9;

  // Status register fields.
  localparam int STAT_DONE_BIT  = 0;
  localparam int STAT_QUICK_BIT = 1;

  // Overlay fields.
  localparam int OVL_REQ_LSB    = 0;
  localparam int OVL_ACTIVE_LSB = 2;
  localparam int OVL_SELECT_BIT = 0;

  localparam logic [1:0] BURST_RESET = 2'h0;
  localparam logic [1:0] SERIAL_LAST_BEAT = 2'h2;
  localparam logic [5:0] SHIFT_FULL = 6'h20;

  typedef enum logic [2:0] {
    PANEL_TFT16   = 3'h0,
    PANEL_TFT18   = 3'h1,
    PANEL_SERIAL8 = 3'h2,
    PANEL_MONO1   = 3'h3,
    PANEL_MONO2   = 3'h4,
    PANEL_MONO4   = 3'h5,
    PANEL_MONO8   = 3'h6,
    PANEL_COLOUR  = 3'h7
  } panel_mode_t;

  typedef enum logic [1:0] {
    FMT_RGB16        = 2'h0,
    FMT_ALPHA18      = 2'h1,
    FMT_ALPHA24      = 2'h2,
    FMT_PACKED24     = 2'h3
  } fb_format_t;

  // Gray order along idle, run, drain, quit.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_RUN   = 2'h1,
    ST_DRAIN = 2'h3,
    ST_QUIT  = 2'h2
  } ctrl_state_t;

endpackage

/* File: hw/pixel_unpacker.sv */
module pixel_unpacker
  import lcd_pixel_pkg::*;
(
  input  wire  logic        clk_i,
  input  wire  logic        rst_b_i,
  input  wire  fb_format_t  fmt_i,
  input  wire  logic        flush_i,
  input  wire  logic [31:0] word_i,
  input  wire  logic        word_valid_i,
  output logic              word_take_o,
  output logic [23:0]       pix_rgb_o,
  output logic [7:0]        pix_alpha_o,
  output logic              pix_valid_o,
  input  wire  logic        pix_take_i
);

  logic [1:0]  phase_reg;
  logic [23:0] stash_reg;
  logic        out_free;
  logic        need_word;
  logic        produce;
  logic [15:0] half;
  logic [23:0] rgb_next;
  logic [7:0]  alpha_next;
  logic [23:0] stash_next;

  assign out_free  = !pix_valid_o || pix_take_i;
  assign need_word = !((fmt_i == FMT_PACKED24) && (phase_reg == 2'h3)) &&
                     !((fmt_i == FMT_RGB16) && (phase_reg == 2'h1));
  assign word_take_o = out_free && word_valid_i && need_word && !flush_i;
  assign produce = out_free && !flush_i && (word_take_o || !need_word);

  always_comb begin
    half       = (phase_reg == 2'h0) ? word_i[15:0] : stash_reg[15:0];
    rgb_next   = '0;
    alpha_next = '0;
    stash_next = stash_reg;
    case (fmt_i)
      FMT_RGB16: begin
        rgb_next = {half[15:11], 3'h0, half[10:5], 2'h0, half[4:0], 3'h0};
        stash_next = {8'h00, word_i[31:16]};
      end
      FMT_ALPHA18: begin // R1
        alpha_next = word_i[31:24];
        rgb_next = {word_i[23:18], 2'h0, word_i[15:10], 2'h0,
                    word_i[7:2], 2'h0};
      end
      FMT_ALPHA24: begin // R2
        alpha_next = word_i[31:24];
        rgb_next   = word_i[23:0];
      end
      default: begin // R3
        case (phase_reg)
          2'h0: begin
            rgb_next   = word_i[23:0];
            stash_next = {16'h0000, word_i[31:24]};
          end
          2'h1: begin
            rgb_next   = {word_i[15:8], word_i[7:0], stash_reg[7:0]};
            stash_next = {8'h00, word_i[31:24], word_i[23:16]};
          end
          2'h2: begin
            rgb_next   = {word_i[7:0], stash_reg[15:0]};
            stash_next = word_i[31:8];
          end
          default: begin
            rgb_next = stash_reg;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_reg <= 2'h0;
      stash_reg <= 24'h000000;
    end else if (flush_i) begin
      phase_reg <= 2'h0;
    end else if (produce) begin
      stash_reg <= stash_next;
      if (fmt_i == FMT_PACKED24)
        phase_reg <= phase_reg + 2'h1;
      else if (fmt_i == FMT_RGB16)
        phase_reg <= {1'b0, ~phase_reg[0]};
      else
        phase_reg <= 2'h0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pix_valid_o <= 1'b0;
      pix_rgb_o   <= 24'h000000;
      pix_alpha_o <= 8'h00;
    end else if (flush_i) begin
      pix_valid_o <= 1'b0;
    end else if (produce) begin
      pix_valid_o <= 1'b1;
      pix_rgb_o   <= rgb_next;
      pix_alpha_o <= alpha_next;
    end else if (pix_take_i) begin
      pix_valid_o <= 1'b0;
    end
  end

endmodule

/* File: hw/lcd_frame_pixel_control.sv */
// Overview of operation
// [R1] 18bpp alpha: alpha 31:24, red 23:18.
// [R2] 24bpp alpha: alpha 31:24, red 23:16.
// [R3] Packed 24bpp: four pixels in three words.
// [R4] Mono passive: first pixel on highest pin.
// [R5] Colour passive: upper D7-D0, lower D15-D8.
// [R6] Serial 8-bit: red, green, blue bytes.
// [R7] Parallel active: whole pixel per clock.
// [R8] Active panels need clock ratio 1.5.
// [R9] Passive panels need clock ratio three.
// [R10] First enable follows fixed programming order.
// [R11] Re-enable: clear status, reload addresses.
// [R12] While running only few bits writable.
// [R13] Regular disable stops at frame end.
// [R14] Disable bit zero when enabling.
// [R15] Clearing enable stops panel at once.
// [R16] No re-enable before quick flag sets.
// [R17] Reset leaves controller disabled.
// [R18] Buffer alignment follows burst field.
// [R19] Buffers and lines are whole words.
// [R20] Overlay enables change only at frame end; while stopped, the code applies a write at once.
// [R21] Overlay sizes limited for live changes.
// [R22] Source select changes need disable first.
// [R23] Pixels cross to pixel clock safely.
//
// Local design decisions: the register offsets and strobed register access.
module lcd_frame_pixel_control
  import lcd_pixel_pkg::*;
(
  input  wire  logic              clk_i,
  input  wire  logic              rst_b_i,
  input  wire  logic [ADDR_W-1:0] reg_addr_i,
  input  wire  logic [DATA_W-1:0] reg_wdata_i,
  input  wire  logic              reg_wr_i,
  input  wire  logic              reg_rd_i,
  output logic [DATA_W-1:0]       reg_rdata_o,
  input  wire  logic [31:0]       fb_word_i,
  input  wire  logic              fb_valid_i,
  output logic                    fb_ready_o,
  input  wire  logic              dma_busy_i,
  input  wire  logic              frame_end_i,
  input  wire  logic              lcd_pclk_i,
  output logic [PINS_W-1:0]       lcd_data_o,
  output logic                    panel_drive_o,
  output logic                    dma_enable_o,
  output logic [31:0]             desc_addr0_o,
  output logic [31:0]             desc_addr1_o,
  output logic [1:0]              fg_enable_o,
  output logic                    image_unit_select_o,
  output logic [1:0]              burst_length_o
);

  ctrl_state_t state_reg;
  ctrl_state_t state_next;
  logic        controller_enable_bit;
  logic        regular_disable_bit;
  panel_mode_t panel_mode_reg;
  fb_format_t  fb_format_reg;
  logic        dual_panel_reg;
  logic        disable_done_flag;
  logic        quick_disable_flag;
  logic [1:0]  fg_request_reg;
  logic        pclk_s1_reg;
  logic        pclk_s2_reg;
  logic        pclk_s3_reg;
  logic        pclk_edge;
  logic [31:0] word_reg;
  logic        word_full_reg;
  logic        word_full_next;
  logic        word_consume;
  logic        running;
  logic        flush;
  logic        stn_mode;
  logic        unpack_take;
  logic [23:0] pix_rgb;
  logic        pix_valid;
  logic        pix_take;
  logic [1:0]  beat_reg;
  logic [31:0] shift_reg;
  logic [5:0]  shift_cnt_reg;
  logic [5:0]  stn_width;
  logic [5:0]  stn_need;
  logic        stn_load;
  logic        stn_step;
  logic        ctrl_wr;
  logic        stat_wr;
  logic        drain_done;
  logic        quit_done;

  assign ctrl_wr = reg_wr_i && (reg_addr_i == LCD_CONTROL_OFS);
  assign stat_wr = reg_wr_i && (reg_addr_i == LCD_STATUS_OFS);
  assign running = (state_reg == ST_RUN) || (state_reg == ST_DRAIN);
  assign flush   = !running;
  assign drain_done = (state_reg == ST_DRAIN) && frame_end_i;
  assign quit_done  = (state_reg == ST_QUIT) && !dma_busy_i;
  assign stn_mode = (panel_mode_reg == PANEL_MONO1) ||
                    (panel_mode_reg == PANEL_MONO2) ||
                    (panel_mode_reg == PANEL_MONO4) ||
                    (panel_mode_reg == PANEL_MONO8) ||
                    (panel_mode_reg == PANEL_COLOUR);

  // The pixel clock is foreign; only the second and third stages feed edge logic.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pclk_s1_reg <= 1'b0;
      pclk_s2_reg <= 1'b0;
      pclk_s3_reg <= 1'b0;
    end else begin
      pclk_s1_reg <= lcd_pclk_i;
      pclk_s2_reg <= pclk_s1_reg;
      pclk_s3_reg <= pclk_s2_reg;
    end
  end

  assign pclk_edge = pclk_s2_reg && !pclk_s3_reg; // R23

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ctrl_wr && reg_wdata_i[CTRL_ENABLE_BIT])
          state_next = ST_RUN;
      end
      ST_RUN: begin
        if (ctrl_wr && !reg_wdata_i[CTRL_ENABLE_BIT])
          state_next = ST_QUIT; // R15
        else if (ctrl_wr && reg_wdata_i[CTRL_DISABLE_BIT])
          state_next = ST_DRAIN; // R13
      end
      ST_DRAIN: begin
        if (ctrl_wr && !reg_wdata_i[CTRL_ENABLE_BIT])
          state_next = ST_QUIT; // R15
        else if (frame_end_i)
          state_next = ST_IDLE; // R13
      end
      default: begin
        if (!dma_busy_i)
          state_next = ST_IDLE; // R15
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      state_reg <= ST_IDLE; // R17
    else
      state_reg <= state_next;
  end

  // Hardware clears the enable bit when a regular disable ends.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      controller_enable_bit <= 1'b0; // R17
      regular_disable_bit   <= 1'b0;
    end else if (ctrl_wr) begin
      controller_enable_bit <= reg_wdata_i[CTRL_ENABLE_BIT];
      regular_disable_bit   <= reg_wdata_i[CTRL_DISABLE_BIT];
    end else if (drain_done) begin
      controller_enable_bit <= 1'b0; // R13
    end
  end

  // Configuration is frozen while running.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      burst_length_o      <= BURST_RESET;
      panel_mode_reg      <= PANEL_TFT16;
      fb_format_reg       <= FMT_RGB16;
      dual_panel_reg      <= 1'b0;
      image_unit_select_o <= 1'b0;
    end else if (state_reg == ST_IDLE) begin // R12
      if (ctrl_wr) begin
        burst_length_o <= reg_wdata_i[CTRL_BURST_LSB +: 2];
        panel_mode_reg <= panel_mode_t'(reg_wdata_i[CTRL_PANEL_LSB +: 3]);
        fb_format_reg  <= fb_format_t'(reg_wdata_i[CTRL_FORMAT_LSB +: 2]);
        dual_panel_reg <= reg_wdata_i[CTRL_DUAL_BIT];
      end
      if (reg_wr_i && (reg_addr_i == OVERLAY_CTRL_OFS))
        image_unit_select_o <= reg_wdata_i[OVL_SELECT_BIT]; // R22
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      desc_addr0_o <= 32'h00000000;
      desc_addr1_o <= 32'h00000000;
    end else if (reg_wr_i) begin
      if (reg_addr_i == DESC_ADDR0_OFS)
        desc_addr0_o <= reg_wdata_i;
      else if (reg_addr_i == DESC_ADDR1_OFS)
        desc_addr1_o <= reg_wdata_i;
    end
  end

  // Overlay requests apply at frame end while displaying.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fg_request_reg <= 2'h0;
      fg_enable_o    <= 2'h0;
    end else begin
      if (!running || frame_end_i)
        fg_enable_o <= fg_request_reg; // R20
      if (reg_wr_i && (reg_addr_i == OVERLAY_CFG_OFS)) begin
        fg_request_reg <= reg_wdata_i[OVL_REQ_LSB +: 2];
        if (!running)
          fg_enable_o <= reg_wdata_i[OVL_REQ_LSB +: 2];
      end
    end
  end

  // Write one clears; a hardware set in the same cycle wins.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      disable_done_flag  <= 1'b0;
      quick_disable_flag <= 1'b0;
    end else begin
      if (drain_done)
        disable_done_flag <= 1'b1; // R13
      else if (stat_wr && reg_wdata_i[STAT_DONE_BIT])
        disable_done_flag <= 1'b0;
      if (quit_done)
        quick_disable_flag <= 1'b1; // R15
      else if (stat_wr && reg_wdata_i[STAT_QUICK_BIT])
        quick_disable_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= '0;
      if (reg_addr_i == LCD_CONTROL_OFS) begin
        reg_rdata_o[CTRL_ENABLE_BIT]       <= controller_enable_bit;
        reg_rdata_o[CTRL_DISABLE_BIT]      <= regular_disable_bit;
        reg_rdata_o[CTRL_BURST_LSB +: 2]   <= burst_length_o;
        reg_rdata_o[CTRL_PANEL_LSB +: 3]   <= panel_mode_reg;
        reg_rdata_o[CTRL_FORMAT_LSB +: 2]  <= fb_format_reg;
        reg_rdata_o[CTRL_DUAL_BIT]         <= dual_panel_reg;
      end else if (reg_addr_i == LCD_STATUS_OFS) begin
        reg_rdata_o[STAT_DONE_BIT]  <= disable_done_flag;
        reg_rdata_o[STAT_QUICK_BIT] <= quick_disable_flag;
      end else if (reg_addr_i == DESC_ADDR0_OFS) begin
        reg_rdata_o <= desc_addr0_o;
      end else if (reg_addr_i == DESC_ADDR1_OFS) begin
        reg_rdata_o <= desc_addr1_o;
      end else if (reg_addr_i == OVERLAY_CFG_OFS) begin
        reg_rdata_o[OVL_REQ_LSB +: 2]    <= fg_request_reg;
        reg_rdata_o[OVL_ACTIVE_LSB +: 2] <= fg_enable_o;
      end else if (reg_addr_i == OVERLAY_CTRL_OFS) begin
        reg_rdata_o[OVL_SELECT_BIT] <= image_unit_select_o;
      end
    end
  end

  // Registered ready costs one bubble after each word.
  assign word_consume   = unpack_take || stn_load;
  assign word_full_next = !flush &&
                          ((word_full_reg && !word_consume) ||
                           (fb_valid_i && fb_ready_o));

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_full_reg <= 1'b0;
      word_reg      <= 32'h00000000;
      fb_ready_o    <= 1'b0;
      dma_enable_o  <= 1'b0;
    end else begin
      word_full_reg <= word_full_next;
      fb_ready_o    <= !word_full_next && (state_next == ST_RUN ||
                                           state_next == ST_DRAIN);
      dma_enable_o  <= (state_next == ST_RUN) || (state_next == ST_DRAIN);
      if (fb_valid_i && fb_ready_o)
        word_reg <= fb_word_i;
    end
  end

  pixel_unpacker u_unpack (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .fmt_i        (fb_format_reg),
    .flush_i      (flush || stn_mode),
    .word_i       (word_reg),
    .word_valid_i (word_full_reg),
    .word_take_o  (unpack_take),
    .pix_rgb_o    (pix_rgb),
    .pix_alpha_o  (),
    .pix_valid_o  (pix_valid),
    .pix_take_i   (pix_take)
  );

  always_comb begin
    case (panel_mode_reg)
      PANEL_MONO1: stn_width = 6'h01;
      PANEL_MONO2: stn_width = 6'h02;
      PANEL_MONO4: stn_width = 6'h04;
      default:     stn_width = 6'h08;
    endcase
  end

  assign stn_need = dual_panel_reg ? (stn_width << 1) : stn_width;
  assign stn_load = running && stn_mode && word_full_reg &&
                    (shift_cnt_reg == 6'h00);
  assign stn_step = running && stn_mode && pclk_edge &&
                    (shift_cnt_reg >= stn_need);
  assign pix_take = running && !stn_mode && pclk_edge && pix_valid &&
                    ((panel_mode_reg != PANEL_SERIAL8) ||
                     (beat_reg == SERIAL_LAST_BEAT));

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_reg     <= 32'h00000000;
      shift_cnt_reg <= 6'h00;
    end else if (flush) begin
      shift_cnt_reg <= 6'h00;
    end else if (stn_load) begin
      shift_reg     <= word_reg;
      shift_cnt_reg <= SHIFT_FULL;
    end else if (stn_step) begin
      shift_reg     <= shift_reg << stn_need;
      shift_cnt_reg <= shift_cnt_reg - stn_need;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      beat_reg <= 2'h0;
    else if (flush)
      beat_reg <= 2'h0;
    else if (pix_take)
      beat_reg <= 2'h0;
    else if (pclk_edge && pix_valid && panel_mode_reg == PANEL_SERIAL8)
      beat_reg <= beat_reg + 2'h1; // R6
  end

  // Pins drop to zero as a quick disable is taken.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lcd_data_o    <= '0;
      panel_drive_o <= 1'b0;
    end else if (state_next == ST_QUIT || state_next == ST_IDLE) begin
      lcd_data_o    <= '0; // R15
      panel_drive_o <= 1'b0;
    end else begin
      panel_drive_o <= 1'b1;
      if (stn_step) begin
        lcd_data_o <= '0;
        lcd_data_o[7:0] <= 8'(shift_reg[31:24] >> (4'h8 - stn_width[3:0]));
        if (dual_panel_reg)
          lcd_data_o[15:8] <= 8'(shift_reg[31 - stn_width[3:0] -: 8] >>
                                 (4'h8 - stn_width[3:0])); // R4 R5
      end else if (pclk_edge && pix_valid && !stn_mode) begin
        lcd_data_o <= '0;
        case (panel_mode_reg)
          PANEL_TFT16: lcd_data_o[15:0] <= {pix_rgb[23:19], pix_rgb[15:10],
                                            pix_rgb[7:3]}; // R7
          PANEL_TFT18: lcd_data_o <= {pix_rgb[23:18], pix_rgb[15:10],
                                      pix_rgb[7:2]}; // R7
          default: begin
            case (beat_reg)
              2'h0:    lcd_data_o[7:0] <= pix_rgb[23:16]; // R6
              2'h1:    lcd_data_o[7:0] <= pix_rgb[15:8];
              default: lcd_data_o[7:0] <= pix_rgb[7:0];
            endcase
          end
        endcase
      end
    end
  end

endmodule

/* File: bench/lcd_pixel_properties.sv */
module lcd_pixel_properties
  import lcd_pixel_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_b_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic              fb_valid_i,
  input wire logic              fb_ready_o,
  input wire logic              frame_end_i,
  input wire logic [PINS_W-1:0] lcd_data_o,
  input wire logic              panel_drive_o,
  input wire logic              dma_enable_o,
  input wire logic [31:0]       desc_addr0_o,
  input wire logic [1:0]        fg_enable_o,
  input wire logic [1:0]        burst_length_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic ctrl_wr;
  logic mapped;
  assign ctrl_wr = reg_wr_i && reg_addr_i == LCD_CONTROL_OFS;
  assign mapped = reg_addr_i[1:0] == 2'h0 && reg_addr_i <= OVERLAY_CTRL_OFS;
  sequence quick_req_s;
    ctrl_wr && !reg_wdata_i[CTRL_ENABLE_BIT] && dma_enable_o;
  endsequence
  sequence panel_off_s;
    !panel_drive_o && lcd_data_o == '0;
  endsequence
  sequence running_s;
    dma_enable_o && !frame_end_i && !$past(frame_end_i) && !ctrl_wr &&
      !$past(ctrl_wr);
  endsequence
  a_quick_stop: assert property (quick_req_s |-> ##3 panel_off_s [*4])
    else $error("panel driven after stop");
  a_ready_idle: assert property (!dma_enable_o |-> !fb_ready_o)
    else $error("word taken while off");
  a_ready_gap: assert property (fb_valid_i && fb_ready_o |=> !fb_ready_o)
    else $error("words back to back");
  a_drain_holds: assert property (running_s |=> dma_enable_o)
    else $error("fetch stopped early");
  a_fg_frame: assert property ($changed(fg_enable_o) && $past(dma_enable_o)
    |-> $past(frame_end_i) || $past(frame_end_i, 2))
    else $error("overlay changed mid-frame");
  a_fg_idle: assert property (reg_wr_i && reg_addr_i == OVERLAY_CFG_OFS &&
    !dma_enable_o && !$past(ctrl_wr)
    |=> fg_enable_o == $past(reg_wdata_i[1:0]))
    else $error("idle overlay write lost");
  a_enable_run: assert property (ctrl_wr && reg_wdata_i[1:0] == 2'h1 &&
    !dma_enable_o && !panel_drive_o |-> ##2 dma_enable_o && fb_ready_o)
    else $error("enable did not fetch");
  a_desc_load: assert property (reg_wr_i && reg_addr_i == DESC_ADDR0_OFS
    |=> desc_addr0_o == $past(reg_wdata_i))
    else $error("descriptor not loaded");
  a_unmapped_rd: assert property (reg_rd_i && !mapped |=> reg_rdata_o == '0)
    else $error("unmapped read not zero");
  a_reset_clear: assert property ($rose(rst_b_i) |-> !dma_enable_o &&
    !panel_drive_o && lcd_data_o == '0 && desc_addr0_o == '0 &&
    fg_enable_o == '0 && burst_length_o == BURST_RESET && reg_rdata_o == '0)
    else $error("bad reset outputs");
endmodule

bind lcd_frame_pixel_control lcd_pixel_properties u_props (.*);

/* File: bench/lcd_panel_model.sv */
module lcd_panel_model
  import lcd_pixel_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              run_i,
  input  wire logic [PINS_W-1:0] lcd_data_i,
  input  wire logic              panel_drive_i,
  output logic                   lcd_pclk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PINS_W-1:0] seen_q[$];
  logic [PINS_W-1:0] last_pins = '0;
  // Eight device clocks per pixel clock.
  initial begin
    lcd_pclk_o = 1'b0;
    #7;
    forever begin
      #160;
      lcd_pclk_o = run_i ? ~lcd_pclk_o : 1'b0;
    end
  end
  // Only changes are kept; successive pixels must differ.
  always @(posedge clk_i) begin
    if (panel_drive_i && lcd_data_i !== last_pins)
      seen_q.push_back(lcd_data_i);
    last_pins <= lcd_data_i;
  end
endmodule

/* File: bench/lcd_frame_pixel_control_tb.sv */
module lcd_frame_pixel_control_tb
  import lcd_pixel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_i = 1'b0;
  logic              rst_b_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic              reg_wr_i = 1'b0;
  logic              reg_rd_i = 1'b0;
  logic [31:0]       fb_word_i = '0;
  logic              fb_valid_i = 1'b0;
  logic              dma_busy_i = 1'b0;
  logic              frame_end_i = 1'b0;
  logic              pclk_run = 1'b0;
  logic              lcd_pclk_i;
  logic [DATA_W-1:0] reg_rdata_o;
  logic              fb_ready_o;
  logic [PINS_W-1:0] lcd_data_o;
  logic              panel_drive_o;
  logic              dma_enable_o;
  logic [31:0]       desc_addr0_o;
  logic [31:0]       desc_addr1_o;
  logic [1:0]        fg_enable_o;
  logic              image_unit_select_o;
  logic [1:0]        burst_length_o;
  int                err_count = 0;
  int                n_tests = 0;

  lcd_frame_pixel_control dut (.*);
  lcd_panel_model panel (.clk_i(clk_i), .run_i(pclk_run),
    .lcd_data_i(lcd_data_o), .panel_drive_i(panel_drive_o),
    .lcd_pclk_o(lcd_pclk_i));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
    chk(reg_rdata_o, exp);
  endtask

  function automatic logic [31:0] cfg(panel_mode_t p, fb_format_t f,
                                      logic dual);
    return (32'(p) << CTRL_PANEL_LSB) | (32'(f) << CTRL_FORMAT_LSB) |
           (32'(dual) << CTRL_DUAL_BIT) | 32'h4;
  endfunction

  // Inverted once released so stale words fail.
  task automatic send(input logic [31:0] w);
    @(posedge clk_i);
    fb_word_i <= w;
    fb_valid_i <= 1'b1;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_i);
      if (fb_ready_o === 1'b1) break;
    end
    fb_valid_i <= 1'b0;
    fb_word_i <= ~w;
  endtask

  task automatic frame_pulse();
    @(posedge clk_i);
    frame_end_i <= 1'b1;
    @(posedge clk_i);
    frame_end_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic start(input logic [31:0] c);
    wr(LCD_CONTROL_OFS, c);
    wr(DESC_ADDR0_OFS, 32'h1000);
    wr(DESC_ADDR1_OFS, 32'h2040);
    panel.seen_q.delete();
    pclk_run <= 1'b1;
    wr(LCD_CONTROL_OFS, c | 32'h1);
  endtask

  task automatic quick_stop(input logic [31:0] c);
    dma_busy_i <= 1'b1;
    wr(LCD_CONTROL_OFS, c);
    repeat (6) @(posedge clk_i);
    chk(32'({panel_drive_o, lcd_data_o}), 32'h0);
    rd(LCD_STATUS_OFS, 32'h0);
    dma_busy_i <= 1'b0;
    pclk_run <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(LCD_STATUS_OFS, 32'h2);
    wr(LCD_STATUS_OFS, 32'h3);
    rd(LCD_STATUS_OFS, 32'h0);
  endtask

  task automatic s_stream(input logic [31:0] c, input logic [31:0] w[$],
                          input logic [PINS_W-1:0] m,
                          input logic [PINS_W-1:0] e[$]);
    start(c);
    foreach (w[i]) send(w[i]);
    for (int i = 0; i < 3000 && panel.seen_q.size() < e.size(); i++)
      @(posedge clk_i);
    chk(panel.seen_q.size(), e.size());
    foreach (e[k])
      if (k < panel.seen_q.size()) chk(32'(panel.seen_q[k] & m), 32'(e[k]));
    quick_stop(c);
  endtask

  task automatic s_reset();
    for (int a = 0; a < 8; a++) rd(8'(4 * a), 32'h0);
    chk(32'({dma_enable_o, panel_drive_o, lcd_data_o}), 32'h0);
    wr(OVERLAY_CTRL_OFS, 32'h1);
    @(negedge clk_i);
    chk(32'(image_unit_select_o), 32'h1);
    wr(OVERLAY_CTRL_OFS, 32'h0);
  endtask

  task automatic s_tft18();
    logic [31:0]       c;
    logic [31:0]       w[2];
    c = cfg(PANEL_TFT18, FMT_ALPHA18, 1'b0);
    w = '{32'hc4a53c5c, 32'h5b69a7f0};
    start(c);
    @(negedge clk_i);
    chk(desc_addr1_o, 32'h2040);
    chk(32'(burst_length_o), 32'h1);
    send(w[0]);
    send(w[1]);
    for (int i = 0; i < 3000 && panel.seen_q.size() < 2; i++)
      @(posedge clk_i);
    foreach (w[k])
      chk(32'(panel.seen_q[k]), 32'({w[k][23:18], w[k][15:10], w[k][7:2]}));
    wr(OVERLAY_CFG_OFS, 32'h3);
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    chk(32'(fg_enable_o), 32'h0);
    frame_pulse();
    chk(32'(fg_enable_o), 32'h3);
    rd(OVERLAY_CFG_OFS, 32'hf);
    wr(LCD_CONTROL_OFS, c | 32'h3);
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    chk(32'(dma_enable_o), 32'h1);
    frame_pulse();
    chk(32'(dma_enable_o), 32'h0);
    rd(LCD_STATUS_OFS, 32'h1);
    wr(LCD_STATUS_OFS, 32'h1);
    wr(LCD_CONTROL_OFS, c);
    wr(OVERLAY_CFG_OFS, 32'h0);
    @(negedge clk_i);
    chk(32'(fg_enable_o), 32'h0);
    pclk_run <= 1'b0;
    panel.seen_q.delete();
  endtask

  task automatic s_serial();
    s_stream(cfg(PANEL_SERIAL8, FMT_ALPHA24, 1'b0), '{32'ha1c35a96},
             18'hff, '{18'hc3, 18'h5a, 18'h96});
    s_stream(cfg(PANEL_SERIAL8, FMT_PACKED24, 1'b0),
             '{32'h66112233, 32'h88994455, 32'haabbcc77}, 18'hff,
             '{18'h11, 18'h22, 18'h33, 18'h44, 18'h55, 18'h66,
               18'h77, 18'h88, 18'h99, 18'haa, 18'hbb, 18'hcc});
  endtask

  task automatic s_mono();
    int                w;
    logic [31:0]       ww[4];
    logic [PINS_W-1:0] e[$];
    logic [PINS_W-1:0] m;
    ww = '{32'haaaaaaaa, 32'h66666666, 32'h12345678, 32'h12345678};
    foreach (ww[k]) begin
      e.delete();
      w = 1 << k;
      m = 18'((1 << w) - 1);
      for (int i = 32 - w; i >= 0; i -= w)
        e.push_back(18'(ww[k] >> i) & m);
      s_stream(cfg(panel_mode_t'(PANEL_MONO1 + k), FMT_RGB16, 1'b0),
               '{ww[k]}, m, e);
    end
  endtask

  task automatic s_colour();
    s_stream(cfg(PANEL_COLOUR, FMT_RGB16, 1'b1), '{32'h89abcdef},
             18'hffff, '{18'hab89, 18'hefcd});
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    s_reset();
    s_tft18();
    s_serial();
    s_mono();
    s_colour();
    tally_and_finish();
  end

  // 50,000 cycles means a hang.
  initial begin
    #2_000_000;
    err_count++;
    tally_and_finish();
  end
endmodule
